/* rtl/stdr_regs.sv */
// Scan bridge test data registers: mode, identity, compactor, clock counter
`timescale 1ns/100ps
module stdr_regs
    import stdr_pkg::*;
#(
    parameter int unsigned NUM_PORTS = 3,
    parameter logic [31:0] ID_VALUE = 32'h0A5C3001 // Arbitrary identity value
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic tck_b_in,
    input wire logic tap_tlr_in,
    input wire logic [2:0] dr_sel_in,
    input wire logic capture_dr_in,
    input wire logic shift_dr_in,
    input wire logic update_dr_in,
    input wire logic cntr_on_in,
    input wire logic parked_in,
    input wire logic sig_en_in,
    input wire logic local_scan_port_data_in,
    input wire logic local_scan_port_data_vld_in,
    input wire logic tdi_in,
    output logic tdo_out,
    output logic [NUM_PORTS-1:0] local_scan_port_sel_out,
    output logic loopback_out,
    output logic [NUM_PORTS-1:0] local_scan_port_tck_en_out,
    output logic cntr_done_out,
    output logic [NUM_PORTS-1:0] sys_local_scan_port_sel_out,
    output logic sys_loopback_out,
    output logic sys_cntr_done_out
);
    // Only three to eight local ports have select bits
    if (NUM_PORTS < 3 || NUM_PORTS > 8) begin : g_bad_ports
        $error("NUM_PORTS must lie between 3 and 8");
    end

    localparam int unsigned SYS_W = NUM_PORTS + 2;

    logic rstn_t;
    logic rstn_s;
    logic ce_t;
    logic [7:0] mr0_r;
    logic [7:0] mr1_r;
    logic [7:0] mr2_r;
    logic status_r;
    logic [15:0] sig_r;
    logic [31:0] cnt_r;
    logic [31:0] sh_r;
    logic [7:0] sel_all_r;
    logic gate_r;
    logic [SYS_W-1:0] hold_r;
    logic req_r;
    logic req_s;
    logic ack_t;
    logic seen_r;
    logic [SYS_W-1:0] sys_word_r;

    // Reset released through two flops in each domain
    stdr_sync u_rst_tck (
        .clk_in(tck_b_in),
        .rstn_in(rstn_in),
        .en_in(1'b1),
        .d_in(1'b1),
        .q_out(rstn_t)
    );
    stdr_sync u_rst_sys (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .en_in(1'b1),
        .d_in(1'b1),
        .q_out(rstn_s)
    );
    // Clock enable carried into the link domain as a level
    stdr_sync u_ce_tck (
        .clk_in(tck_b_in),
        .rstn_in(rstn_t),
        .en_in(1'b1),
        .d_in(ce_in),
        .q_out(ce_t)
    );

    // Writable masks; absent ports keep their bits at zero
    wire [7:0] mr0_wmask = MR0_BASE_MASK | ((NUM_PORTS > 3) ? MR0_PORT3_MASK : 8'h00) |
                           ((NUM_PORTS > 4) ? MR0_PORT4_MASK : 8'h00);
    wire [2:0] mr1_ports = (NUM_PORTS > 5) ? 3'(8'hFF >> (13 - NUM_PORTS)) : 3'h0;
    wire [7:0] mr1_wmask = MR1_PORTS_MASK & {5'h00, mr1_ports};

    // Data register decode
    wire sel_mode0 = (dr_sel_in == DR_MODE0);
    wire sel_mode1 = (dr_sel_in == DR_MODE1);
    wire sel_mode2 = (dr_sel_in == DR_MODE2);
    wire sel_ident = (dr_sel_in == DR_IDENT);
    wire sel_sig = (dr_sel_in == DR_SIG);
    wire sel_count = (dr_sel_in == DR_COUNT);
    wire sel_mode = sel_mode0 | sel_mode1 | sel_mode2;
    wire [5:0] dr_len = sel_mode ? LEN_MODE : sel_ident ? LEN_IDENT : sel_sig ? LEN_SIG :
                        sel_count ? LEN_COUNT : LEN_BYPASS;
    wire do_capture = ce_t & capture_dr_in;
    wire do_shift = ce_t & shift_dr_in;
    wire do_update = ce_t & update_dr_in;

    // First mode register read value carries live counter status
    wire [7:0] mr0_rd = {status_r, mr0_r[6:0]};
    wire [31:0] cap_val = sel_mode0 ? {24'h000000, mr0_rd} :
                          sel_mode1 ? {24'h000000, mr1_r} :
                          sel_mode2 ? {24'h000000, mr2_r} :
                          sel_ident ? ID_VALUE :
                          sel_sig ? {16'h0000, sig_r} :
                          sel_count ? cnt_r : 32'h00000000;

    // Shift enters at the top of the selected length; upper bits stay zero
    wire [4:0] top_pos = 5'(dr_len - 6'h01);
    wire [31:0] sh_ins = {31'h00000000, tdi_in} << top_pos;
    wire [31:0] sh_shifted = {1'b0, sh_r[31:1]} | sh_ins;

    // Scan path register
    always_ff @(posedge tck_b_in or negedge rstn_t) begin
        if (!rstn_t) begin
            sh_r <= 32'h00000000;
        end else if (do_capture) begin
            sh_r <= cap_val;
        end else if (do_shift) begin
            sh_r <= sh_shifted;
        end
    end
    assign tdo_out = sh_r[0];

    // Mode register writes at update
    wire [7:0] sh_byte = sh_r[7:0];
    wire mr0_wr = do_update & sel_mode0;
    wire mr1_wr = do_update & sel_mode1;
    wire mr2_wr = do_update & sel_mode2;
    always_ff @(posedge tck_b_in or negedge rstn_t) begin
        if (!rstn_t) begin
            mr0_r <= MR0_RST;
            mr1_r <= MR1_RST;
            mr2_r <= MR2_RST;
        end else if (ce_t && tap_tlr_in) begin
            mr0_r <= MR0_RST;
            mr1_r <= MR1_RST;
            mr2_r <= MR2_RST;
        end else begin
            if (mr0_wr) begin
                mr0_r <= sh_byte & mr0_wmask;
            end
            if (mr1_wr) begin
                mr1_r <= sh_byte & mr1_wmask;
            end
            if (mr2_wr) begin
                mr2_r <= sh_byte;
            end
        end
    end

    // Signature compactor: serial input, Galois feedback
    wire sig_step = ce_t & sig_en_in & local_scan_port_data_vld_in;
    wire sig_fb = sig_r[15] ^ local_scan_port_data_in;
    wire [15:0] sig_nxt = {sig_r[14:0], 1'b0} ^ (sig_fb ? SIG_POLY : 16'h0000);
    wire sig_wr = do_update & sel_sig;
    always_ff @(posedge tck_b_in or negedge rstn_t) begin
        if (!rstn_t) begin
            sig_r <= SIG_RST;
        end else if (ce_t && tap_tlr_in) begin
            sig_r <= SIG_RST;
        end else if (sig_wr) begin
            sig_r <= sh_r[15:0];
        end else if (sig_step) begin
            sig_r <= sig_nxt;
        end
    end

    // Test clock counter; pulses count only while gate is open
    wire cnt_load = do_update & sel_count;
    wire cnt_zero = (cnt_r == 32'h00000000);
    wire cnt_dec = ce_t & cntr_on_in & parked_in & ~cnt_zero & gate_r;
    always_ff @(posedge tck_b_in or negedge rstn_t) begin
        if (!rstn_t) begin
            cnt_r <= CNT_RST;
        end else if (ce_t && tap_tlr_in) begin
            cnt_r <= CNT_RST;
        end else if (cnt_load) begin
            cnt_r <= sh_r;
        end else if (cnt_dec) begin
            cnt_r <= cnt_r - 32'h00000001;
        end
    end

    // Status: load or test-logic reset clears it, otherwise it tracks enabled terminal count
    wire status_nxt = cntr_on_in & cnt_zero;
    always_ff @(posedge tck_b_in or negedge rstn_t) begin
        if (!rstn_t) begin
            status_r <= 1'b0;
        end else if (ce_t) begin
            if (tap_tlr_in || cnt_load) begin
                status_r <= 1'b0;
            end else begin
                status_r <= status_nxt;
            end
        end
    end
    assign cntr_done_out = status_r;

    // Local clock gate; counter overrides the free-running choice while on
    wire frdis = mr0_r[MR0_FRDIS_BIT];
    wire stop_cnt = cntr_on_in & cnt_zero;
    wire stop_fr = ~cntr_on_in & frdis;
    wire gate_nxt = ~(parked_in & (stop_cnt | stop_fr));
    wire [7:0] sel_all = {mr1_r[2:0], mr0_r[6:5], mr0_r[2:0]};
    always_ff @(posedge tck_b_in or negedge rstn_t) begin
        if (!rstn_t) begin
            gate_r <= 1'b1;
            sel_all_r <= {5'h00, MR0_RST[2:0]};
        end else if (ce_t) begin
            gate_r <= gate_nxt;
            sel_all_r <= sel_all;
        end
    end
    assign local_scan_port_tck_en_out = {NUM_PORTS{gate_r}};
    assign local_scan_port_sel_out = sel_all_r[NUM_PORTS-1:0];
    assign loopback_out = mr0_r[MR0_LOOP_BIT];

    // Settings cross as one word under a toggle handshake,
    // so a changing selection never shows a mix of old and new bits
    wire [SYS_W-1:0] sys_src = {status_r, mr0_r[MR0_LOOP_BIT], sel_all_r[NUM_PORTS-1:0]};
    wire xfer_idle = (req_r == ack_t);
    wire xfer_start = ce_t & xfer_idle & (sys_src != hold_r);
    always_ff @(posedge tck_b_in or negedge rstn_t) begin
        if (!rstn_t) begin
            hold_r <= {SYS_W{1'b0}};
            req_r <= 1'b0;
        end else if (xfer_start) begin
            hold_r <= sys_src; // Held still until the system side answers
            req_r <= ~req_r;
        end
    end

    // Request toggle into the system domain, answer toggle back
    stdr_sync u_req_sys (
        .clk_in(clk_in),
        .rstn_in(rstn_s),
        .en_in(ce_in),
        .d_in(req_r),
        .q_out(req_s)
    );
    stdr_sync u_ack_tck (
        .clk_in(tck_b_in),
        .rstn_in(rstn_t),
        .en_in(ce_t),
        .d_in(seen_r),
        .q_out(ack_t)
    );

    // Word is stable in hold_r while a new toggle is pending
    always_ff @(posedge clk_in or negedge rstn_s) begin
        if (!rstn_s) begin
            seen_r <= 1'b0;
            sys_word_r <= {SYS_W{1'b0}};
        end else if (ce_in && (req_s != seen_r)) begin
            seen_r <= req_s;
            sys_word_r <= hold_r;
        end
    end
    assign sys_local_scan_port_sel_out = sys_word_r[NUM_PORTS-1:0];
    assign sys_loopback_out = sys_word_r[NUM_PORTS];
    assign sys_cntr_done_out = sys_word_r[NUM_PORTS+1];

    // Checks in the link domain
    AST_STATUS_SET: assert property (@(posedge tck_b_in) disable iff (!rstn_t)
        ce_t && cntr_on_in && cnt_zero && !cnt_load && !tap_tlr_in |=> status_r)
        else $error("status not set at enabled terminal count");
    AST_STATUS_CLR: assert property (@(posedge tck_b_in) disable iff (!rstn_t)
        cnt_load |=> !status_r)
        else $error("status not cleared by counter load");
    AST_STATUS_OFF: assert property (@(posedge tck_b_in) disable iff (!rstn_t)
        ce_t && (tap_tlr_in || !cntr_on_in) |=> !status_r)
        else $error("status set without enabled counter");
    AST_RSVD_ZERO: assert property (@(posedge tck_b_in) disable iff (!rstn_t)
        mr1_r[7:3] == 5'h00 && mr0_r[7] == 1'b0)
        else $error("reserved mode bit holds one");
    AST_ID_CAPTURE: assert property (@(posedge tck_b_in) disable iff (!rstn_t)
        do_capture && sel_ident |=> sh_r == ID_VALUE ##1 (tdo_out == ID_VALUE[1] || !$past(do_shift)))
        else $error("identity value not captured");
    AST_SIG_POLY: assert property (@(posedge tck_b_in) disable iff (!rstn_t)
        sig_step && !sig_wr && !tap_tlr_in && sig_r == 16'h0000 && local_scan_port_data_in
        |=> sig_r == 16'h100B)
        else $error("compactor feedback wrong");
    AST_SIG_HOLD: assert property (@(posedge tck_b_in) disable iff (!rstn_t)
        !sig_step && !sig_wr && !tap_tlr_in |=> $stable(sig_r))
        else $error("compactor moved without a local bit");
    AST_CNT_DEC: assert property (@(posedge tck_b_in) disable iff (!rstn_t)
        cnt_dec && !cnt_load && !tap_tlr_in |=> cnt_r == $past(cnt_r) - 32'h00000001)
        else $error("counter did not step down by one");
    AST_CNT_GATE: assert property (@(posedge tck_b_in) disable iff (!rstn_t)
        ce_t && parked_in && cntr_on_in && cnt_zero |=> !local_scan_port_tck_en_out[0])
        else $error("parked clock runs at terminal count");
    AST_FR_DISABLE: assert property (@(posedge tck_b_in) disable iff (!rstn_t)
        ce_t && parked_in && !cntr_on_in && frdis |=> local_scan_port_tck_en_out == {NUM_PORTS{1'b0}})
        else $error("parked clocks run with free-running disabled");
endmodule

/* rtl/stdr_pkg.sv */
// Shared constants for the scan bridge test data registers
package stdr_pkg;
    // Data register select codes, decoded by the bridge TAP
    localparam logic [2:0] DR_BYPASS = 3'h0;
    localparam logic [2:0] DR_MODE0 = 3'h1;
    localparam logic [2:0] DR_MODE1 = 3'h2;
    localparam logic [2:0] DR_MODE2 = 3'h3;
    localparam logic [2:0] DR_IDENT = 3'h4;
    localparam logic [2:0] DR_SIG = 3'h5;
    localparam logic [2:0] DR_COUNT = 3'h6;
    // Scan lengths of each data register
    localparam logic [5:0] LEN_BYPASS = 6'h01;
    localparam logic [5:0] LEN_MODE = 6'h08;
    localparam logic [5:0] LEN_IDENT = 6'h20;
    localparam logic [5:0] LEN_SIG = 6'h10;
    localparam logic [5:0] LEN_COUNT = 6'h20;
    // Reset values
    localparam logic [7:0] MR0_RST = 8'h01;
    localparam logic [7:0] MR1_RST = 8'h00;
    localparam logic [7:0] MR2_RST = 8'h00;
    localparam logic [15:0] SIG_RST = 16'h0000;
    localparam logic [31:0] CNT_RST = 32'h00000000;
    // Field positions in the first mode register
    localparam int unsigned MR0_STATUS_BIT = 7;
    localparam int unsigned MR0_LOOP_BIT = 4;
    localparam int unsigned MR0_FRDIS_BIT = 3;
    // Writable bits of the mode registers
    localparam logic [7:0] MR0_BASE_MASK = 8'h1F;
    localparam logic [7:0] MR0_PORT3_MASK = 8'h20;
    localparam logic [7:0] MR0_PORT4_MASK = 8'h40;
    localparam logic [7:0] MR1_PORTS_MASK = 8'h07;
    // Compactor feedback taps x^12, x^3, x^1, x^0
    localparam logic [15:0] SIG_POLY = 16'h100B;
endpackage

/* rtl/stdr_sync.sv */
// Two-stage level synchroniser with hold enable
`timescale 1ns/100ps
module stdr_sync (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic en_in,
    input wire logic d_in,
    output logic q_out
);
    logic meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_r <= 1'b0;
            q_out <= 1'b0;
        end else if (en_in) begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule

/* dv/stdr_master.sv */
// Backplane test master model driving data register scans
`timescale 1ns/100ps
module stdr_master
    import stdr_pkg::*;
(
    input wire logic tck_in,
    input wire logic tdo_in,
    output logic [2:0] dr_sel_out,
    output logic capture_out,
    output logic shift_out,
    output logic update_out,
    output logic tdi_out,
    output logic [31:0] rd_data_out,
    output logic rd_vld_out
);
    // Idle levels at time zero
    initial begin
        dr_sel_out = DR_BYPASS;
        capture_out = 1'b0;
        shift_out = 1'b0;
        update_out = 1'b0;
        tdi_out = 1'b0;
        rd_data_out = 32'h00000000;
        rd_vld_out = 1'b0;
    end
    // Capture, len shifts LSB first, update; all changes on falling tck
    task automatic scan(input logic [2:0] sel, input logic [5:0] len, input logic [31:0] din);
        int i;
        @(negedge tck_in);
        dr_sel_out = sel;
        capture_out = 1'b1;
        rd_data_out = 32'h00000000;
        for (i = 0; i < len; i++) begin
            @(negedge tck_in);
            capture_out = 1'b0;
            shift_out = 1'b1;
            tdi_out = din[i];
            rd_data_out[i] = tdo_in;
        end
        @(negedge tck_in);
        shift_out = 1'b0;
        update_out = 1'b1;
        tdi_out = ~tdi_out; // Stale serial data never looks valid
        rd_vld_out = 1'b1;
        @(negedge tck_in);
        update_out = 1'b0;
        rd_vld_out = 1'b0;
    endtask
endmodule

/* dv/test_scan_bridge_test_data_registers.sv */
// Self-checking bench for the scan bridge test data registers
`timescale 1ns/100ps
module test_scan_bridge_test_data_registers;
    import stdr_pkg::*;
    localparam logic [31:0] ID_CODE = 32'h5EED0117; // Arbitrary identity value
    logic clk_in, tck, rstn, ce, tlr, on, park, sig_en, loc_d, loc_vld;
    logic [2:0] dr_sel;
    logic cap, sh, upd, tdi, tdo, rd_vld, loop, done, sys_loop, sys_done;
    logic [7:0] sel, tck_en, sys_sel;
    logic [31:0] rd_data, r;
    logic [31:0] exp_q[$];
    logic [15:0] sig_m;
    int errors = 0;
    int tests_run = 0;
    int seed = 3707;
    int i;
    // System clock and unrelated link clock
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    initial begin
        tck = 1'b0;
        #3;
        forever #7.5 tck = ~tck;
    end
    stdr_regs #(.NUM_PORTS(8), .ID_VALUE(ID_CODE)) stdr_regs_inst (
        .clk_in(clk_in), .rstn_in(rstn), .ce_in(ce), .tck_b_in(tck), .tap_tlr_in(tlr), .dr_sel_in(dr_sel),
        .capture_dr_in(cap), .shift_dr_in(sh), .update_dr_in(upd), .cntr_on_in(on), .parked_in(park),
        .sig_en_in(sig_en), .local_scan_port_data_in(loc_d), .local_scan_port_data_vld_in(loc_vld),
        .tdi_in(tdi), .tdo_out(tdo), .local_scan_port_sel_out(sel), .loopback_out(loop),
        .local_scan_port_tck_en_out(tck_en), .cntr_done_out(done),
        .sys_local_scan_port_sel_out(sys_sel), .sys_loopback_out(sys_loop), .sys_cntr_done_out(sys_done));
    stdr_master stdr_master_inst (
        .tck_in(tck), .tdo_in(tdo), .dr_sel_out(dr_sel), .capture_out(cap), .shift_out(sh),
        .update_out(upd), .tdi_out(tdi), .rd_data_out(rd_data), .rd_vld_out(rd_vld));
    task automatic end_sim();
        if (errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Note the expected capture, then scan
    task automatic rd(input logic [2:0] s, input logic [5:0] len, input logic [31:0] din, input logic [31:0] exp);
        exp_q.push_back(exp);
        stdr_master_inst.scan(s, len, din);
    endtask
    task automatic tw(input int n);
        repeat (n) @(negedge tck);
    endtask
    // Bounded wait for the counter status
    task automatic wait_done(input int lim);
        int n;
        n = 0;
        while (done !== 1'b1) begin
            @(negedge tck);
            n++;
            if (n > lim) begin
                check(done, 1'b1, "status timeout");
                end_sim();
            end
        end
    endtask
    // Scan results are compared in arrival order
    always @(posedge tck) begin
        if (rd_vld === 1'b1 && exp_q.size() > 0) begin
            check(rd_data, exp_q.pop_front(), "scan data");
        end
    end
    initial begin
        {rstn, tlr, on, park, sig_en, loc_d, loc_vld} = 7'h00;
        ce = 1'b1;
        repeat (6) @(posedge clk_in);
        @(negedge clk_in);
        rstn = 1'b1;
        tw(8);
        rd(DR_MODE0, LEN_MODE, 32'hFF, {24'h0, MR0_RST});
        rd(DR_MODE1, LEN_MODE, 32'hFF, 32'h00);
        park = 1'b1;
        tw(3);
        check(sel, 8'hFF, "all ports");
        check(loop, 1'b1, "loopback");
        check(tck_en, 8'h00, "parked stop");
        rd(DR_MODE1, LEN_MODE, 32'h00, 32'h07);
        rd(DR_MODE0, LEN_MODE, 32'h02, 32'h7F);
        tw(3);
        check(sel, 8'h02, "one port");
        check(tck_en, 8'hFF, "parked run");
        repeat (12) @(negedge clk_in);
        check(sys_sel, 8'h02, "sys select");
        rd(DR_MODE2, LEN_MODE, 32'hA5, 32'h00);
        rd(DR_MODE2, LEN_MODE, 32'h00, 32'hA5);
        rd(DR_BYPASS, LEN_BYPASS, 32'h1, 32'h0);
        rd(DR_IDENT, LEN_IDENT, 32'hFFFFFFFF, ID_CODE);
        rd(DR_IDENT, LEN_IDENT, 32'h0, ID_CODE);
        // Random upstream bits, strobed every other cycle
        rd(DR_SIG, LEN_SIG, 32'h0, {16'h0, SIG_RST});
        sig_m = SIG_RST;
        sig_en = 1'b1;
        for (i = 0; i < 40; i++) begin
            @(negedge tck);
            r = $random(seed);
            loc_d = r[0];
            loc_vld = i[0];
            if (i[0]) begin
                sig_m = {sig_m[14:0], 1'b0} ^ ((sig_m[15] ^ r[0]) ? SIG_POLY : 16'h0000);
            end
        end
        @(negedge tck);
        {sig_en, loc_vld} = 2'b00;
        rd(DR_SIG, LEN_SIG, 32'h0, {16'h0, sig_m});
        // Count-down self-test on a parked port
        rd(DR_COUNT, LEN_COUNT, 32'h0, CNT_RST);
        on = 1'b1;
        tw(3);
        check(done, 1'b1, "status at zero");
        check(tck_en, 8'h00, "gate at zero");
        rd(DR_COUNT, LEN_COUNT, 32'h0000000A, 32'h0);
        check(done, 1'b0, "status on load");
        tw(8);
        check(done, 1'b0, "still counting");
        check(tck_en, 8'hFF, "clock runs");
        wait_done(6);
        tw(1);
        check(tck_en, 8'h00, "gate at count end");
        repeat (12) @(negedge clk_in);
        check(sys_done, 1'b1, "sys status");
        check(sys_loop, 1'b0, "sys loopback off");
        rd(DR_MODE0, LEN_MODE, 32'h1C, 32'h82);
        rd(DR_COUNT, LEN_COUNT, 32'h0, 32'h0);
        on = 1'b0;
        tw(3);
        check(done, 1'b0, "status off");
        check(loop, 1'b1, "loopback set");
        repeat (12) @(negedge clk_in);
        check(sys_loop, 1'b1, "sys loopback on");
        check(sys_done, 1'b0, "sys status off");
        tw(1);
        tlr = 1'b1;
        tw(1);
        tlr = 1'b0;
        rd(DR_MODE0, LEN_MODE, 32'h0, {24'h0, MR0_RST});
        // Second reset in mid-run
        rstn = 1'b0;
        tw(2);
        check(sel, 8'h01, "sel in reset");
        rstn = 1'b1;
        tw(8);
        rd(DR_COUNT, LEN_COUNT, 32'h0, CNT_RST);
        tw(2);
        check(exp_q.size(), 0, "pending scans");
        end_sim();
    end
endmodule
